// >>> sstx_fifo.sv
`timescale 1ns/1ps
module sstx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_q];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sstx_fifo

// >>> sstx_pkg.sv
package sstx_pkg;

    // ****************************************
    // Field widths and link parameters
    // ****************************************
    localparam int DATA_W      = 32;
    localparam int CHAN_W      = 4;
    localparam int ERR_W       = 2;
    localparam int EMPTY_W     = 2;
    localparam int SYMS_PER_BEAT = 4;
    localparam int FIFO_DEPTH  = 4;
    localparam int READY_LAT   = 0;
    localparam int READY_LAT_MAX = 8;
    localparam logic [CHAN_W-1:0] HIGHEST_CHANNEL_LIMIT = 4'h000f;

    // ****************************************
    // Beat carrier
    // ****************************************
    typedef struct packed {
        logic [DATA_W-1:0]  data;
        logic [CHAN_W-1:0]  chan;
        logic [ERR_W-1:0]   err;
        logic [EMPTY_W-1:0] empty;
        logic               sop;
        logic               eop;
    } sstx_beat_t;

    localparam int BEAT_W = $bits(sstx_beat_t);

    typedef enum logic [1:0] {
        SSTX_IDLE = 2'h0,
        SSTX_PKT  = 2'h1
    } sstx_state_t;

endpackage : sstx_pkg

// >>> sstx_props.sv
`timescale 1ns/1ps
module sstx_props
    import sstx_pkg::*;
(
    input wire logic              clk_sys, rst_n, usr_valid, usr_ready, st_ready,
    input wire logic              st_valid, st_startofpacket, st_endofpacket, proto_drop,
    input wire logic [DATA_W-1:0] st_data,
    input wire logic [CHAN_W-1:0] st_channel
);
    default clocking @(posedge clk_sys); endclocking
    logic open_q;
    // Packet open on the wire
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            open_q <= 1'b0;
        end else if (st_valid && st_ready) begin
            open_q <= !st_endofpacket;
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    a_reset_quiet: assert property (
        !rst_n |-> !st_valid && !st_startofpacket && !st_endofpacket && usr_ready)
        else $error("stream active in reset");
    a_valid_holds: assert property (
        disable iff (!rst_n) st_valid && !st_ready |=> st_valid)
        else $error("valid dropped while stalled");
    a_fields_stable: assert property (
        disable iff (!rst_n) st_valid && !st_ready |=>
        $stable({st_data, st_channel, st_startofpacket, st_endofpacket}))
        else $error("beat changed while stalled");
    a_launch_time: assert property (
        disable iff (!rst_n) usr_valid && usr_ready && !st_valid |-> ##[1:2] st_valid)
        else $error("beat not launched");
    a_sop_idle: assert property (
        disable iff (!rst_n) st_valid && !open_q |-> st_startofpacket)
        else $error("first beat without start flag");
    a_sop_open: assert property (
        disable iff (!rst_n) st_valid && open_q |-> !st_startofpacket)
        else $error("new packet inside open packet");
    a_no_drop: assert property (disable iff (!rst_n) !proto_drop)
        else $error("legal beat dropped");
    a_refuse_busy: assert property (disable iff (!rst_n) !usr_ready |-> st_valid)
        else $error("refused with idle output");
    cover property (st_valid && st_ready && st_endofpacket);
    cover property (st_valid && !st_ready);
    cover property (!usr_ready);
endmodule : sstx_props

// >>> sstx_sink.sv
`timescale 1ns/1ps
module sstx_sink
    import sstx_pkg::*;
(
    input wire logic               clk_sys, rst_n, st_valid, st_startofpacket, st_endofpacket,
    input wire logic [1:0]         sink_mode,
    input wire logic [DATA_W-1:0]  st_data,
    input wire logic [CHAN_W-1:0]  st_channel,
    input wire logic [ERR_W-1:0]   st_error,
    input wire logic [EMPTY_W-1:0] st_empty,
    output logic                   st_ready
);
    sstx_beat_t got[$];
    // Mode 0 prompt, 1 every other cycle, 2 stalled
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ready <= 1'b0;
        end else begin
            st_ready <= (sink_mode == 2'h0) || (sink_mode == 2'h1 && !st_ready);
            if (st_valid && st_ready) begin
                got.push_back({st_data, st_channel, st_error, st_empty, st_startofpacket,
                    st_endofpacket});
            end
        end
    end
endmodule : sstx_sink

// >>> sstx_source.sv
`timescale 1ns/1ps
// Operation
// [RULE1] All stream signals are active high at source and sink.
// [RULE2] One instance per signal role; same meaning at both ends.
// [RULE3] Channel field names the channel of the same-cycle data.
// [RULE4] Channel field comes with a highest channel limit parameter.
// [RULE5] Data field carries the bulk of the transfer, 1 to 8192 bits.
// [RULE6] Source drives an error mask, one bit per error class.
// [RULE7] Ready in cycle n makes cycle n plus latency a ready cycle.
// [RULE8] Source asserts valid only in ready cycles.
// [RULE9] Sink captures fields only in ready cycles with valid high.
// [RULE10] A source lacking ready connects only to sinks without backpressure.
// [RULE11] A sink lacking ready accepts every transfer offered.
// [RULE12] A source lacking valid presents data whenever not backpressured.
// [RULE13] A sink lacking valid treats unstalled cycles as valid.
// [RULE14] Empty field counts symbols in the beat holding no data.
// [RULE15] First-beat flag marks the beat that begins a packet.
// [RULE16] Last-beat flag marks the beat that ends a packet.
// [RULE17] Backpressure is optional and lets the sink halt flow.
// [RULE18] Each beat is a single-cycle transfer of one or more symbols.
// [RULE19] All transfers occur on the rising edge of one clock.
// [RULE20] Source outputs come straight from rising-edge flip-flops.
// [RULE21] Ready latency is 0 to 8 cycles, default 0.
// [RULE22] Reset holds valid and packet flags low.
// [RULE23] A begun packet is ended before a new one starts.
module sstx_source
    import sstx_pkg::*;
#(
    parameter int READY_LATENCY = READY_LAT
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic [DATA_W-1:0]   usr_data,
    input  wire logic [CHAN_W-1:0]   usr_chan,
    input  wire logic [ERR_W-1:0]    usr_err,
    input  wire logic [EMPTY_W-1:0]  usr_empty,
    input  wire logic                usr_sop,
    input  wire logic                usr_eop,
    input  wire logic                usr_valid,
    output logic                     usr_ready,
    output logic [DATA_W-1:0]        st_data,
    output logic [CHAN_W-1:0]        st_channel,
    output logic [ERR_W-1:0]         st_error,
    output logic [EMPTY_W-1:0]       st_empty,
    output logic                     st_startofpacket,
    output logic                     st_endofpacket,
    output logic                     st_valid,
    input  wire logic                st_ready,
    output logic                     proto_drop
);

    // ****************************************
    // Input buffer
    // ****************************************
    sstx_beat_t in_beat;
    sstx_beat_t in_clean;
    sstx_beat_t head;
    logic       in_valid;
    logic       head_valid;
    logic       head_take;
    logic       fifo_ready;

    // Packet tracking
    sstx_state_t state_q;
    logic        bad_beat;

    // Out-of-range channels and illegal empty counts are dropped
    always_comb begin
        in_beat       = '0;         // RULE2
        in_beat.data  = usr_data;   // RULE5
        in_beat.chan  = usr_chan;   // RULE3
        in_beat.err   = usr_err;    // RULE6
        in_beat.empty = usr_empty;  // RULE14
        in_beat.sop   = usr_sop;
        in_beat.eop   = usr_eop;
        in_clean      = in_beat;
        bad_beat      = (usr_chan > HIGHEST_CHANNEL_LIMIT) // RULE4
                     || (32'(usr_empty) >= SYMS_PER_BEAT);
    end

    assign in_valid  = usr_valid && !bad_beat;
    assign usr_ready = fifo_ready || bad_beat;

    sstx_fifo #(
        .WIDTH (BEAT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_data   (in_clean),
        .in_valid  (in_valid),
        .in_ready  (fifo_ready),
        .out_data  (head),
        .out_valid (head_valid),
        .out_ready (head_take)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            proto_drop <= 1'b0;
        end else begin
            proto_drop <= usr_valid && bad_beat;
        end
    end

    // ****************************************
    // Ready latency pipeline
    // ****************************************
    logic [READY_LAT_MAX:0] rdy_hist_q;
    logic                   ready_cycle;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdy_hist_q <= '0;
        end else begin
            rdy_hist_q <= {rdy_hist_q[READY_LAT_MAX-1:0], st_ready}; // RULE19
        end
    end

    // History tap that lines up with the cycle after the launch edge
    localparam int RDY_SEL = (READY_LATENCY > 1) ? READY_LATENCY - 2 : 0;

    // Outputs are registered, so the beat launched now is seen next cycle
    always_comb begin
        if (READY_LATENCY == 0) begin
            ready_cycle = 1'b1; // RULE10
        end else if (READY_LATENCY == 1) begin
            ready_cycle = st_ready; // RULE7 RULE21
        end else begin
            ready_cycle = rdy_hist_q[RDY_SEL]; // RULE7 RULE21
        end
    end

    // ****************************************
    // Output stage
    // ****************************************
    logic out_busy;
    logic launch;
    logic sop_fix;
    logic eop_fix;

    // Latency 0: beat stands until taken; else slot decided a cycle early
    assign out_busy  = (READY_LATENCY == 0) && st_valid && !st_ready; // RULE17
    assign launch    = head_valid && !out_busy && ready_cycle;         // RULE8 RULE12
    assign head_take = launch;

    // Force a close of an open packet before a new start
    always_comb begin
        sop_fix = head.sop;
        eop_fix = head.eop;
        if (state_q == SSTX_PKT && head.sop) begin
            sop_fix = 1'b0; // RULE23
            eop_fix = 1'b1; // RULE23
        end
        if (state_q == SSTX_IDLE && !head.sop) begin
            sop_fix = 1'b1; // RULE15
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_valid         <= 1'b0; // RULE22
            st_startofpacket <= 1'b0; // RULE22
            st_endofpacket   <= 1'b0; // RULE22
        end else if (!out_busy) begin
            st_valid         <= launch;                // RULE20 RULE18 RULE1
            st_startofpacket <= launch && sop_fix;      // RULE15
            st_endofpacket   <= launch && eop_fix;      // RULE16
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_data    <= '0;
            st_channel <= '0;
            st_error   <= '0;
            st_empty   <= '0;
        end else if (launch) begin
            st_data    <= head.data;  // RULE20 RULE5
            st_channel <= head.chan;  // RULE3
            st_error   <= head.err;   // RULE6
            st_empty   <= head.empty; // RULE14
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SSTX_IDLE;
        end else if (launch) begin
            case (state_q)
                SSTX_IDLE: begin
                    if (!eop_fix) begin
                        state_q <= SSTX_PKT;
                    end
                end
                SSTX_PKT: begin
                    if (eop_fix) begin
                        state_q <= SSTX_IDLE; // RULE23
                    end
                end
                default: begin
                    state_q <= SSTX_IDLE;
                end
            endcase
        end
    end

endmodule : sstx_source

// >>> streaming_source_sink_link_tb.sv
`timescale 1ns/1ps
module streaming_source_sink_link_tb
    import sstx_pkg::*;
;
    logic               clk_sys, rst_n, usr_valid, usr_sop, usr_eop, usr_ready, st_ready;
    logic               st_valid, st_startofpacket, st_endofpacket, proto_drop;
    logic [DATA_W-1:0]  usr_data, st_data;
    logic [CHAN_W-1:0]  usr_chan, st_channel;
    logic [ERR_W-1:0]   usr_err, st_error;
    logic [EMPTY_W-1:0] usr_empty, st_empty;
    logic [1:0]         sink_mode;
    int                 miscompares, samples_checked, n;
    sstx_source sstx_source_i (.clk_sys, .rst_n, .usr_data, .usr_chan, .usr_err, .usr_empty,
        .usr_sop, .usr_eop, .usr_valid, .usr_ready, .st_data, .st_channel, .st_error,
        .st_empty, .st_startofpacket, .st_endofpacket, .st_valid, .st_ready, .proto_drop);
    sstx_sink sstx_sink_i (.clk_sys, .rst_n, .st_valid, .st_startofpacket, .st_endofpacket,
        .sink_mode, .st_data, .st_channel, .st_error, .st_empty, .st_ready);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [BEAT_W-1:0] beat(logic [DATA_W-1:0] d, logic s, logic e);
        return {d, d[3:0], d[5:4], d[7:6], s, e};
    endfunction : beat
    task automatic chk(string nm, logic [BEAT_W-1:0] e, logic [BEAT_W-1:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic send(logic [DATA_W-1:0] d, logic s, logic e);
        @(posedge clk_sys);
        usr_valid <= 1'b1;
        {usr_data, usr_chan, usr_err, usr_empty, usr_sop, usr_eop} <= beat(d, s, e);
        @(negedge clk_sys);
        while (usr_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        usr_valid <= 1'b0;
    endtask : send
    task automatic drain(int k);
        repeat (200) if (sstx_sink_i.got.size() < k) @(posedge clk_sys);
        chk("beats", BEAT_W'(k), BEAT_W'(sstx_sink_i.got.size()));
    endtask : drain
    task automatic t_repair;
        send(32'h1111_0001, 1'b1, 1'b0);
        send(32'h2222_0002, 1'b1, 1'b0);
        send(32'h3333_0003, 1'b0, 1'b1);
        drain(3);
        chk("open", beat(32'h1111_0001, 1'b1, 1'b0), sstx_sink_i.got.pop_front());
        chk("close", beat(32'h2222_0002, 1'b0, 1'b1), sstx_sink_i.got.pop_front());
        chk("forced", beat(32'h3333_0003, 1'b1, 1'b1), sstx_sink_i.got.pop_front());
        $display("repair done");
    endtask : t_repair
    task automatic t_fill;
        n = 0;
        sink_mode <= 2'h2;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            usr_valid <= 1'b1;
            {usr_data, usr_chan, usr_err, usr_empty, usr_sop, usr_eop} <=
                beat(32'h5A00_0000 + n, 1'b1, 1'b1);
            @(negedge clk_sys);
            if (usr_ready === 1'b1) n++;
        end
        @(posedge clk_sys);
        usr_valid <= 1'b0;
        sink_mode <= 2'h1;
        chk("accepted", BEAT_W'(FIFO_DEPTH + 1), BEAT_W'(n));
        drain(n);
        for (int k = 0; k < n; k++) begin
            chk("drain", beat(32'h5A00_0000 + k, 1'b1, 1'b1),
                sstx_sink_i.got.pop_front());
        end
        $display("fill done");
    endtask : t_fill
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        usr_valid = 1'b0;
        sink_mode = 2'h0;
        {usr_data, usr_chan, usr_err, usr_empty, usr_sop, usr_eop} = '0;
        repeat (6) @(posedge clk_sys);
        chk("reset", BEAT_W'(4'h1),
            BEAT_W'({st_valid, st_startofpacket, st_endofpacket, usr_ready}));
        rst_n <= 1'b1;
        send(32'hC0DE_00E7, 1'b1, 1'b1);
        drain(1);
        chk("single", beat(32'hC0DE_00E7, 1'b1, 1'b1),
            sstx_sink_i.got.pop_front());
        $display("single done");
        t_repair();
        t_fill();
        complete_run();
    end
    initial begin
        #40000;
        miscompares++;
        complete_run();
    end
endmodule : streaming_source_sink_link_tb
bind sstx_source sstx_props sstx_props_i (.clk_sys, .rst_n, .usr_valid, .usr_ready, .st_ready,
    .st_valid, .st_startofpacket, .st_endofpacket, .proto_drop, .st_data, .st_channel);
